// >>> inc/sat_defs.svh
// Contract
// - translation enabled only when strap is low while Phase A is high
// - during on-chip memory address cycles the internal bus is a logical address
// - relocated block is descriptor base plus block number
// - block number checked against descriptor size; excess flags a size violation
// - effective ring compared with read, write or execute ring of descriptor
// - no violation: relocated block joined with offset drives physical address
// - memory cycles latch the descriptor index on Phase A trailing edge
// - load-index op loads address register on Phase A leading edge
// - address register addressing only for descriptor access and limited checks
// - zero upper segment bits: index from bus bits 15:12, bit 5 clear
// - nonzero upper segment bits: index from those bits, bit 5 set
// - size-write or low-read op increments address register on leading edge
// - array holds 32-bit entries: 16 small and 15 large segments
// - index 16 has no storage
// - descriptor holds validity, 12-bit base, three rings, 9-bit block size
// - violations set error flags and trap unless next microword clears error
// - array written and read as two 16-bit halves over internal bus
`ifndef SAT_DEFS_SVH
`define SAT_DEFS_SVH
`define SAT_BUS_W 20
`define SAT_DESC_W 32
`define SAT_HALF_W 16
`define SAT_IDX_W 5
`define SAT_ENTRIES 31
`define SAT_GAP_IDX 5'h10
`define SAT_SEG_HI 19:16
`define SAT_SEG_LO 15:12
`define SAT_BLK_SMALL 11:8
`define SAT_BLK_LARGE 15:8
`define SAT_OFFSET 7:0
`define SAT_BASE_W 12
`define SAT_SIZE_W 9
`define SAT_RING_W 2
`define SAT_F_VALID 31
`define SAT_F_BASE 27:16
`define SAT_F_RR 15:14
`define SAT_F_RW 13:12
`define SAT_F_RE 11:10
`define SAT_F_SIZE 8:0
`define SAT_F_HIGH 31:16
`define SAT_F_LOW 15:0
`define SAT_ZERO_IDX 5'h00
`define SAT_ONE_IDX 5'h01
`define SAT_ZERO_NIB 4'h0
`define SAT_ZERO_DESC 32'h0000_0000
`define SAT_ZERO_HALF 16'h0000
`define SAT_ZERO_ADDR 20'h0_0000
`define SAT_ZERO_BLK4 5'h00
`define SAT_ZERO_BLK8 1'h0
`define SAT_ZERO_RING 2'h0
`endif

// >>> inc/sat_pkg.sv
package sat_pkg;
    typedef enum logic [1:0]
    {
        SAT_ACC_READ = 2'h0,
        SAT_ACC_WRITE = 2'h1,
        SAT_ACC_EXEC = 2'h2
    } sat_access_t;

    typedef enum logic [1:0]
    {
        SAT_IDLE = 2'b01,
        SAT_ARMED = 2'b10
    } sat_trap_state_t;
endpackage : sat_pkg

// >>> core/sat_translator.sv
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.svh"
module sat_translator
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic phaseA,
    input wire logic translationOptionStrap,
    input wire logic [`SAT_BUS_W-1:0] internalBus,
    input wire logic memCycle,
    input wire logic onChipAddr,
    input wire sat_pkg::sat_access_t accessType,
    input wire logic [`SAT_RING_W-1:0] effectiveRing,
    input wire logic loadIndexOp,
    input wire logic writeBaseOp,
    input wire logic writeSizeOp,
    input wire logic readHighOp,
    input wire logic readLowOp,
    input wire logic limitedReadCheckOp,
    input wire logic limitedWriteCheckOp,
    input wire logic clearMemoryErrorOp,
    output var logic translationEnableOption,
    output var logic [`SAT_BUS_W-1:0] physAddr,
    output var logic physAddrValid,
    output var logic [`SAT_HALF_W-1:0] descReadData,
    output var logic descReadValid,
    output var logic [`SAT_IDX_W-1:0] descIndex,
    output var logic boundsError,
    output var logic accessError,
    output var logic memoryTrap
);
    import sat_pkg::*;

    function automatic logic [`SAT_IDX_W-1:0] sat_index(input logic [`SAT_BUS_W-1:0] bus);
        logic [`SAT_IDX_W-1:0] idx;
        if (bus[`SAT_SEG_HI] == `SAT_ZERO_NIB)
        begin
            idx = {1'b0, bus[`SAT_SEG_LO]};
        end
        else
        begin
            idx = {1'b1, bus[`SAT_SEG_HI]};
        end
        return idx;
    endfunction : sat_index

    // storage skips the missing index, so upper indices shift down by one
    function automatic logic [`SAT_IDX_W-1:0] sat_slot(input logic [`SAT_IDX_W-1:0] idx);
        logic [`SAT_IDX_W-1:0] slot;
        slot = idx[`SAT_IDX_W-1] ? idx - `SAT_ONE_IDX : idx;
        return slot;
    endfunction : sat_slot

    logic [`SAT_DESC_W-1:0] descArray [0:`SAT_ENTRIES-1];

    logic enable_r, enable_nxt;
    logic phaseAPrev_r, phaseAPrev_nxt;
    logic [`SAT_IDX_W-1:0] latchIdx_r, latchIdx_nxt;
    logic [`SAT_IDX_W-1:0] addrReg_r, addrReg_nxt;
    logic [`SAT_BUS_W-1:0] physAddr_r, physAddr_nxt;
    logic physValid_r, physValid_nxt;
    logic [`SAT_HALF_W-1:0] readData_r, readData_nxt;
    logic readValid_r, readValid_nxt;
    logic bounds_r, bounds_nxt;
    logic access_r, access_nxt;
    logic trap_r, trap_nxt;
    sat_trap_state_t state_r, state_nxt;

    logic leadEdge, trailEdge, regMode, limitedOp, xlateCycle, checkNow;
    logic boundsSet, accessSet, errClear, writeEn;
    logic [`SAT_IDX_W-1:0] busIdx, selIdx;
    logic [`SAT_DESC_W-1:0] entry;
    logic [`SAT_SIZE_W-1:0] relBlk;
    logic [`SAT_RING_W-1:0] ringSel;
    logic [`SAT_BASE_W-1:0] relocBlk;
    logic sizeViol, ringViol;

    always_comb
    begin
        leadEdge = phaseA & ~phaseAPrev_r;
        trailEdge = ~phaseA & phaseAPrev_r;
        busIdx = sat_index(internalBus);
        limitedOp = limitedReadCheckOp | limitedWriteCheckOp;
        // ordinary memory cycles never use the address register
        regMode = leadEdge & (limitedOp | readHighOp | readLowOp | writeBaseOp
            | writeSizeOp);
        selIdx = regMode ? addrReg_r : latchIdx_r;
        entry = (selIdx == `SAT_GAP_IDX) ? `SAT_ZERO_DESC : descArray[sat_slot(selIdx)];
        // block within segment: 16 blocks in a small one, 256 in a large one
        if (selIdx[`SAT_IDX_W-1])
        begin
            relBlk = {`SAT_ZERO_BLK8, internalBus[`SAT_BLK_LARGE]};
        end
        else
        begin
            relBlk = {`SAT_ZERO_BLK4, internalBus[`SAT_BLK_SMALL]};
        end
        relocBlk = entry[`SAT_F_BASE] + {3'h0, relBlk};
        sizeViol = ~entry[`SAT_F_VALID] | (relBlk >= entry[`SAT_F_SIZE]);
        ringSel = entry[`SAT_F_RR];
        if (limitedWriteCheckOp)
        begin
            ringSel = entry[`SAT_F_RW];
        end
        else if (!limitedReadCheckOp)
        begin
            case (accessType)
                SAT_ACC_READ: ringSel = entry[`SAT_F_RR];
                SAT_ACC_WRITE: ringSel = entry[`SAT_F_RW];
                SAT_ACC_EXEC: ringSel = entry[`SAT_F_RE];
                default: ringSel = entry[`SAT_F_RR];
            endcase
        end
        ringViol = effectiveRing > ringSel;
        // bus is watched all through the low phase once the latch holds the index
        xlateCycle = memCycle & onChipAddr & ~phaseA & ~trailEdge;
        checkNow = enable_r & (xlateCycle | (leadEdge & limitedOp));
        boundsSet = checkNow & sizeViol;
        accessSet = checkNow & ringViol;
        errClear = leadEdge & clearMemoryErrorOp;
        writeEn = leadEdge & (writeBaseOp | writeSizeOp) & (addrReg_r != `SAT_GAP_IDX);

        enable_nxt = phaseA ? ~translationOptionStrap : enable_r;
        phaseAPrev_nxt = phaseA;
        latchIdx_nxt = (trailEdge & memCycle) ? busIdx : latchIdx_r;
        addrReg_nxt = addrReg_r;
        if (leadEdge & loadIndexOp)
        begin
            addrReg_nxt = busIdx;
        end
        else if (leadEdge & (writeSizeOp | readLowOp))
        begin
            addrReg_nxt = addrReg_r + `SAT_ONE_IDX;
        end

        physAddr_nxt = physAddr_r;
        physValid_nxt = 1'b0;
        if (xlateCycle & ~enable_r)
        begin
            physAddr_nxt = internalBus;
            physValid_nxt = 1'b1;
        end
        else if (xlateCycle & ~sizeViol & ~ringViol)
        begin
            physAddr_nxt = {relocBlk, internalBus[`SAT_OFFSET]};
            physValid_nxt = 1'b1;
        end

        readData_nxt = readData_r;
        readValid_nxt = 1'b0;
        if (leadEdge & (readHighOp | readLowOp))
        begin
            readData_nxt = readHighOp ? entry[`SAT_F_HIGH] : entry[`SAT_F_LOW];
            readValid_nxt = 1'b1;
        end

        // a fresh violation beats a clear in the same cycle
        bounds_nxt = boundsSet | (bounds_r & ~errClear);
        access_nxt = accessSet | (access_r & ~errClear);
        trap_nxt = 1'b0;
        state_nxt = state_r;
        case (state_r)
            SAT_IDLE:
            begin
                if (boundsSet | accessSet)
                begin
                    state_nxt = SAT_ARMED;
                end
            end
            SAT_ARMED:
            begin
                if (leadEdge)
                begin
                    trap_nxt = ~clearMemoryErrorOp;
                    state_nxt = (boundsSet | accessSet) ? SAT_ARMED : SAT_IDLE;
                end
            end
            default: state_nxt = SAT_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            enable_r <= 1'b0;
            // starts high: a phase already high at release gives no false leading edge
            phaseAPrev_r <= 1'b1;
            latchIdx_r <= `SAT_ZERO_IDX;
            addrReg_r <= `SAT_ZERO_IDX;
            physAddr_r <= `SAT_ZERO_ADDR;
            physValid_r <= 1'b0;
            readData_r <= `SAT_ZERO_HALF;
            readValid_r <= 1'b0;
            bounds_r <= 1'b0;
            access_r <= 1'b0;
            trap_r <= 1'b0;
            state_r <= SAT_IDLE;
        end
        else
        begin
            enable_r <= enable_nxt;
            phaseAPrev_r <= phaseAPrev_nxt;
            latchIdx_r <= latchIdx_nxt;
            addrReg_r <= addrReg_nxt;
            physAddr_r <= physAddr_nxt;
            physValid_r <= physValid_nxt;
            readData_r <= readData_nxt;
            readValid_r <= readValid_nxt;
            bounds_r <= bounds_nxt;
            access_r <= access_nxt;
            trap_r <= trap_nxt;
            state_r <= state_nxt;
        end
    end

    // array contents are undefined until firmware loads them; no reset on purpose
    always_ff @(posedge clock)
    begin
        if (writeEn & writeBaseOp)
        begin
            descArray[sat_slot(addrReg_r)][`SAT_F_HIGH] <= internalBus[`SAT_F_LOW];
        end
        else if (writeEn)
        begin
            descArray[sat_slot(addrReg_r)][`SAT_F_LOW] <= internalBus[`SAT_F_LOW];
        end
    end

    assign translationEnableOption = enable_r;
    assign physAddr = physAddr_r;
    assign physAddrValid = physValid_r;
    assign descReadData = readData_r;
    assign descReadValid = readValid_r;
    assign descIndex = addrReg_r;
    assign boundsError = bounds_r;
    assign accessError = access_r;
    assign memoryTrap = trap_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence violRaised;
        (boundsSet | accessSet) ##1 (state_r == SAT_ARMED);
    endsequence

    sequence nextWordNoClear;
        (leadEdge & ~clearMemoryErrorOp & (state_r == SAT_ARMED));
    endsequence

    option_strap_a: assert property (phaseA |=> enable_r == !$past(translationOptionStrap))
        else $error("option bit does not follow strap in high phase");
    option_hold_a: assert property (!phaseA |=> $stable(enable_r))
        else $error("option bit changed in low phase");
    latch_index_a: assert property (trailEdge & memCycle |=> latchIdx_r ==
        (($past(internalBus[`SAT_SEG_HI]) == `SAT_ZERO_NIB)
        ? {1'b0, $past(internalBus[`SAT_SEG_LO])}
        : {1'b1, $past(internalBus[`SAT_SEG_HI])}))
        else $error("index latch not loaded from bus");
    small_large_a: assert property (leadEdge & loadIndexOp |=>
        addrReg_r[`SAT_IDX_W-1] == ($past(internalBus[`SAT_SEG_HI]) != `SAT_ZERO_NIB))
        else $error("segment size bit wrong");
    addr_inc_a: assert property (leadEdge & ~loadIndexOp & (writeSizeOp | readLowOp) |=>
        addrReg_r == $past(addrReg_r) + `SAT_ONE_IDX)
        else $error("address register did not step");
    addr_hold_a: assert property (~leadEdge |=> $stable(addrReg_r))
        else $error("address register moved outside leading edge");
    gap_empty_a: assert property (leadEdge & readHighOp & (addrReg_r == `SAT_GAP_IDX) |=>
        descReadData == `SAT_ZERO_HALF)
        else $error("missing index returned data");
    pass_through_a: assert property (xlateCycle & ~enable_r |=>
        physAddrValid && physAddr == $past(internalBus))
        else $error("disabled translation altered address");
    no_flag_off_a: assert property (~enable_r & ~boundsError & ~accessError |=>
        ~boundsError & ~accessError)
        else $error("flag set while translation disabled");
    reloc_out_a: assert property (xlateCycle & enable_r & ~sizeViol & ~ringViol |=>
        physAddrValid && physAddr[`SAT_OFFSET] == $past(internalBus[`SAT_OFFSET])
        && physAddr[`SAT_BUS_W-1:8] == $past(relocBlk))
        else $error("physical address not relocated");
    size_flag_a: assert property (checkNow & sizeViol |=> boundsError && !physAddrValid)
        else $error("size violation not flagged");
    ring_flag_a: assert property (checkNow & (effectiveRing > ringSel) |=> accessError)
        else $error("ring violation not flagged");
    trap_fire_a: assert property (violRaised ##[0:300] nextWordNoClear |=>
        memoryTrap ##1 !memoryTrap)
        else $error("trap missing after violation");
    trap_quiet_a: assert property (leadEdge & clearMemoryErrorOp |=> !memoryTrap)
        else $error("trap raised despite clear");
endmodule : sat_translator
`default_nettype wire

// >>> tb/sat_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.svh"
// only the address phase of main memory is modelled; data words never reach this block
module sat_mem_model
(
    input wire logic clock,
    input wire logic [`SAT_BUS_W-1:0] physAddr,
    input wire logic physAddrValid,
    output var logic [`SAT_BUS_W-1:0] lastAddr,
    output var int hits
);
    initial
    begin
        lastAddr = 20'hF_FFFF;
        hits = 0;
    end
    always @(posedge clock)
    begin
        if (physAddrValid === 1'b1)
        begin
            lastAddr <= physAddr;
            hits <= hits + 1;
        end
    end
endmodule : sat_mem_model
`default_nettype wire

// >>> tb/sat_translator_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.svh"
module sat_translator_bench;
    import sat_pkg::*;
    typedef struct
    {
        logic [19:0] bus, phys;
        sat_access_t acc;
        logic [1:0] ring;
        logic bnd, acs;
    } sat_row_t;
    localparam logic [7:0] OP_LOAD = 8'h01, OP_WBASE = 8'h02, OP_WSIZE = 8'h04, OP_RHIGH = 8'h08,
        OP_RLOW = 8'h10, OP_LREAD = 8'h20, OP_LWRITE = 8'h40, OP_CME = 8'h80;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic phaseA = 1'b0;
    logic strap = 1'b0;
    logic onChip = 1'b1;
    logic memCycle = 1'b0;
    logic [19:0] bus = 20'h0_0000;
    logic [7:0] ops = 8'h00;
    logic [1:0] ring = 2'h0;
    logic [15:0] lastRead = 16'h0000;
    sat_access_t accessType = SAT_ACC_READ;
    logic [19:0] physAddr, lastAddr;
    logic [15:0] descReadData;
    logic [4:0] descIndex;
    logic physAddrValid, descReadValid, optOn, boundsError, accessError, memoryTrap;
    int n_fail = 0;
    int n_compared = 0;
    int nTrap = 0;
    int hits, h0;
    sat_row_t rows [8];
    always #4 clock = ~clock;
    sat_translator u_dut
    (
        .clock(clock),
        .reset_n(reset_n),
        .phaseA(phaseA),
        .translationOptionStrap(strap),
        .internalBus(bus),
        .memCycle(memCycle),
        .onChipAddr(onChip),
        .accessType(accessType),
        .effectiveRing(ring),
        .loadIndexOp(ops[0]),
        .writeBaseOp(ops[1]),
        .writeSizeOp(ops[2]),
        .readHighOp(ops[3]),
        .readLowOp(ops[4]),
        .limitedReadCheckOp(ops[5]),
        .limitedWriteCheckOp(ops[6]),
        .clearMemoryErrorOp(ops[7]),
        .translationEnableOption(optOn),
        .physAddr(physAddr),
        .physAddrValid(physAddrValid),
        .descReadData(descReadData),
        .descReadValid(descReadValid),
        .descIndex(descIndex),
        .boundsError(boundsError),
        .accessError(accessError),
        .memoryTrap(memoryTrap)
    );
    sat_mem_model u_mem
    (
        .clock(clock),
        .physAddr(physAddr),
        .physAddrValid(physAddrValid),
        .lastAddr(lastAddr),
        .hits(hits)
    );
    // pulses are caught here so checks need not hit their exact cycle
    always @(posedge clock)
    begin
        if (memoryTrap === 1'b1)
            nTrap <= nTrap + 1;
        if (descReadValid === 1'b1)
            lastRead <= descReadData;
    end
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    // one microcycle: one clock of phase A high, then the low phase
    task automatic mc(input logic [19:0] b, input logic [7:0] o, input logic m = 1'b0,
        input sat_access_t a = SAT_ACC_READ, input logic [1:0] r = 2'h0);
        @(posedge clock);
        phaseA <= 1'b1;
        bus <= b;
        ops <= o;
        memCycle <= m;
        accessType <= a;
        ring <= r;
        @(posedge clock);
        phaseA <= 1'b0;
        ops <= 8'h00;
        repeat (3) @(posedge clock);
        #1;
    endtask : mc
    task automatic wdesc(input logic [19:0] sel, input logic [15:0] hi, input logic [15:0] lo);
        mc(sel, OP_LOAD);
        mc({4'h0, hi}, OP_WBASE);
        mc({4'h0, lo}, OP_WSIZE);
    endtask : wdesc
    initial
    begin
        rows = '{
            '{20'h0_345A, 20'h1_045A, SAT_ACC_READ, 2'h2, 1'b0, 1'b0},
            '{20'h0_39C3, 20'h1_09C3, SAT_ACC_WRITE, 2'h1, 1'b0, 1'b0},
            '{20'h0_3A00, 20'h1_09C3, SAT_ACC_READ, 2'h0, 1'b1, 1'b0},
            '{20'h0_3100, 20'h1_09C3, SAT_ACC_EXEC, 2'h1, 1'b0, 1'b1},
            '{20'h4_FE77, 20'hF_FE77, SAT_ACC_WRITE, 2'h3, 1'b0, 1'b0},
            '{20'h0_5000, 20'hF_FE77, SAT_ACC_EXEC, 2'h0, 1'b1, 1'b0},
            '{20'h0_3000, 20'hF_FE77, SAT_ACC_WRITE, 2'h2, 1'b0, 1'b1},
            '{20'h4_0011, 20'hF_0011, SAT_ACC_EXEC, 2'h3, 1'b0, 1'b0}};
        repeat (15) @(posedge clock);
        #1;
        chk("resetIdle", 20'h0_0000, 20'({optOn, boundsError, accessError, memoryTrap, descIndex}));
        @(posedge clock);
        reset_n <= 1'b1;
        mc(20'h0_0000, 8'h00);
        chk("optionOn", 20'h0_0001, 20'(optOn));
        wdesc(20'h0_3000, 16'h8100, 16'h900A);
        wdesc(20'h4_0000, 16'h8F00, 16'hFDFF);
        wdesc(20'h0_5000, 16'h0123, 16'hFDFF);
        foreach (rows[i])
        begin
            h0 = hits;
            mc(rows[i].bus, 8'h00, 1'b1, rows[i].acc, rows[i].ring);
            chk("boundsError", 20'(rows[i].bnd), 20'(boundsError));
            chk("accessError", 20'(rows[i].acs), 20'(accessError));
            mc(20'h0_0000, OP_CME);
            chk("physAddr", rows[i].phys, lastAddr);
            chk("addrIssued", 20'(!(rows[i].bnd | rows[i].acs)), 20'(hits != h0));
            chk("flagsCleared", 20'h0_0000, 20'({boundsError, accessError}));
        end
        chk("noTrap", 20'h0_0000, 20'(nTrap));
        $display("test table done");
        mc(20'h0_3A00, 8'h00, 1'b1);
        mc(20'h0_0000, 8'h00);
        chk("trap", 20'h0_0001, 20'(nTrap));
        chk("stickyFlag", 20'h0_0001, 20'(boundsError));
        mc(20'h0_0000, OP_CME);
        $display("test trap done");
        mc(20'h0_3000, OP_LOAD);
        chk("idxSmall", 20'h0_0003, 20'(descIndex));
        mc(20'h0_0000, OP_RHIGH);
        chk("readHigh", 20'h0_8100, 20'(lastRead));
        mc(20'h0_0000, OP_RLOW);
        chk("readLow", 20'h0_900A, 20'(lastRead));
        chk("idxStep", 20'h0_0004, 20'(descIndex));
        mc(20'h4_0000, OP_LOAD);
        chk("idxLarge", 20'h0_0014, 20'(descIndex));
        mc(20'h0_F000, OP_LOAD);
        mc(20'h0_1234, OP_WBASE);
        mc(20'h0_0000, OP_WSIZE);
        chk("idxGap", 20'h0_0010, 20'(descIndex));
        mc(20'h0_8ABC, OP_WBASE);
        mc(20'h0_0000, OP_RHIGH);
        chk("gapRead", 20'h0_0000, 20'(lastRead));
        mc(20'h0_F000, OP_LOAD);
        mc(20'h0_0000, OP_RHIGH);
        chk("gapWrite", 20'h0_1234, 20'(lastRead));
        $display("test descriptor done");
        mc(20'h0_3000, OP_LOAD);
        mc(20'h0_0000, OP_LREAD, 1'b0, SAT_ACC_EXEC, 2'h3);
        chk("limitedRead", 20'h0_0001, 20'(accessError));
        mc(20'h0_0000, OP_CME);
        mc(20'h0_0000, OP_LWRITE, 1'b0, SAT_ACC_EXEC, 2'h1);
        chk("limitedWrite", 20'h0_0000, 20'(accessError));
        $display("test limited done");
        @(posedge clock);
        onChip <= 1'b0;
        h0 = hits;
        mc(20'h0_3A00, 8'h00, 1'b1);
        chk("offChip", 20'h0_0000, 20'({boundsError, hits != h0}));
        mc(20'h0_0000, 8'h00);
        $display("test offchip done");
        @(posedge clock);
        strap <= 1'b1;
        onChip <= 1'b1;
        mc(20'h0_0000, 8'h00);
        chk("optionOff", 20'h0_0000, 20'(optOn));
        mc(20'h0_3A00, 8'h00, 1'b1);
        mc(20'h0_0000, 8'h00);
        chk("passThrough", 20'h0_3A00, lastAddr);
        chk("noFlags", 20'h0_0000, 20'({boundsError, accessError}));
        chk("trapTotal", 20'h0_0001, 20'(nTrap));
        $display("test bypass done");
        @(posedge clock);
        reset_n <= 1'b0;
        phaseA <= 1'b1;
        bus <= 20'h4_0000;
        ops <= OP_LOAD;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("resetAgain", 20'h0_0000, 20'({boundsError, accessError, memoryTrap, descIndex}));
        $display("test reset done");
        results();
    end
    // about 50 microcycles of five clocks are expected; this leaves wide margin
    initial
    begin
        repeat (3000) @(posedge clock);
        n_fail++;
        results();
    end
endmodule : sat_translator_bench
`default_nettype wire
